// ==== hdl/tws_defines.svh ====
// register map, field positions, reset values and timing of the two-wire controller
// Overview of operation
// RL1: both lines are only pulled low or released, giving a wired-AND idling high.
// RL2: master waits until the clock line really rises before timing its high period.
// RL3: master makes the bus clock from a programmable prescale, up to 400 kbit/s.
// RL4: master does start, stop, read, write and acknowledge per byte on command.
// RL5: end of every master transfer shows as interrupt and as pollable status bit.
// RL6: after a start the address goes out first, one byte or two for 10-bit.
// RL7: a falling clock from anyone ends our high period and starts our low count.
// RL8: arbitration loss on any driven bit frees the bus and raises an interrupt.
// RL9: software checks acknowledge and arbitration status after every master transfer.
// RL10: slave never makes clock pulses, it only holds the clock low.
// RL11: slave accepts two 7-bit addresses, one 10-bit address or enabled general call.
// RL12: slave ignores reserved addresses 0000 001 to 0000 011, 0000 1XX, 1111 1XX.
// RL13: the all-zero general call is answered only in 7-bit addressing.
// RL14: 1111 0XX starts a 10-bit address, answered only in 10-bit mode.
// RL15: a byte arriving while the last one is unread gets a not-acknowledge.
// RL16: slave transmit and receive share one buffer, a write overwrites preloaded data.
// RL17: slave stretches the clock during a read until software supplies a byte.
// RL18: slave flags read needed, read taken, write available, end of burst, error.
// RL19: optional filter on both inputs rejects pulses shorter than 60 ns.
// RL20: start is data falling with clock high, stop is data rising with clock high.
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
`define TWS_A_PRESC 8'h00
`define TWS_A_CTRL 8'h04
`define TWS_A_CMD 8'h08
`define TWS_A_MSTAT 8'h0C
`define TWS_A_MDATA 8'h10
`define TWS_A_SADDR 8'h14
`define TWS_A_SDATA 8'h18
`define TWS_A_SSTAT 8'h1C
`define TWS_C_MEN 0
`define TWS_C_SEN 1
`define TWS_C_FILT 2
`define TWS_C_GC 3
`define TWS_C_TEN 4
`define TWS_F_DONE 0
`define TWS_F_ARB 1
`define TWS_S_RREQ 0
`define TWS_S_RTAK 1
`define TWS_S_WAV 2
`define TWS_S_EOB 3
`define TWS_S_PERR 4
`define TWS_CTRL_RST 5'h00
`define TWS_SADDR_RST 32'h0000_0000
`define TWS_SYS_HZ 40000000
`define TWS_MAX_BPS 400000
`define TWS_PRESC_RST (`TWS_SYS_HZ / (2 * `TWS_MAX_BPS))
`define TWS_CLK_NS 25
`define TWS_GLITCH_NS 60
`define TWS_FILT_CYC ((`TWS_GLITCH_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`endif

// ==== hdl/tws_pkg.sv ====
// types shared by the two-wire controller
package tws_pkg;
	typedef enum logic [3:0] {
		M_IDLE, M_STA0, M_STA1, M_STA2, M_STA3, M_LOAD, M_LOW, M_HIGH, M_STO0, M_STO1, M_STO2
	} tws_mst_e;
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR2, S_WR, S_RD, S_WAIT} tws_slv_e;
	typedef struct packed {
		logic nak;
		logic wr;
		logic rd;
		logic sto;
		logic sta;
	} tws_cmd_s;
	typedef struct packed {
		logic [5:0] r2;
		logic [9:0] a10;
		logic r1;
		logic [6:0] b;
		logic r0;
		logic [6:0] a;
	} tws_saddr_s;
endpackage : tws_pkg

// ==== hdl/tws_top.sv ====
// two-wire master and slave controller with wishbone register access
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`include "tws_defines.svh"
module tws_top (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// serial lines
	input wire logic serial_clock_line_i,
	input wire logic serial_data_line_i,
	output logic serial_clock_line_o,
	output logic serial_clock_line_oe_o,
	output logic serial_data_line_o,
	output logic serial_data_line_oe_o,
	// events
	output logic master_irq_o,
	output logic slave_irq_o
);
	logic ack_q;
	logic [31:0] rdat_q;
	logic wr;
	logic rd;
	logic [31:0] wm;
	logic [15:0] presc_q;
	logic [4:0] ctrl_q;
	tws_pkg::tws_saddr_s saddr_q;
	logic [7:0] mtx_q;
	logic [1:0] flt;
	logic scl;
	logic sda;
	logic scl_p_q;
	logic sda_p_q;
	logic scl_r;
	logic scl_f;
	logic sta_det;
	logic sto_det;
	logic bus_busy_q;
	tws_pkg::tws_mst_e ms_q;
	tws_pkg::tws_cmd_s cmd_q;
	logic [15:0] mcnt_q;
	logic [3:0] mbit_q;
	logic [8:0] msh_q;
	logic [7:0] mrx_q;
	logic rxnak_q;
	logic m_scl_q;
	logic m_sda_q;
	logic mhi_q;
	logic [1:0] mev_q;
	logic [1:0] mflag_q;
	logic cmdw;
	logic tdone;
	logic own;
	logic hi_end;
	tws_pkg::tws_slv_e sst_q;
	tws_pkg::tws_slv_e snx_q;
	logic [3:0] sbit_q;
	logic [7:0] ssh_q;
	logic [7:0] buf_q;
	logic full_q;
	logic txv_q;
	logic ten_q;
	logic mnak_q;
	logic s_scl_q;
	logic s_sda_q;
	logic [4:0] sev_q;
	logic [4:0] sflag_q;
	logic sact;
	logic [6:0] sa;
	logic hit7;
	logic pre10;
	logic lo_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic mirq_q;
	logic sirq_q;

	function automatic logic [31:0] mwr(input logic [31:0] o, input logic [31:0] d,
		input logic [31:0] m);
		return (o & ~m) | (d & m);
	endfunction : mwr

	// wishbone slave, one wait state
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
	assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;
	assign wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
			if (rd) begin
				case (wb_adr_i)
					`TWS_A_PRESC: rdat_q <= {16'h0000, presc_q};
					`TWS_A_CTRL: rdat_q <= {27'h0000000, ctrl_q};
					`TWS_A_MSTAT: rdat_q <= {27'h0000000, bus_busy_q, ms_q != tws_pkg::M_IDLE,
						rxnak_q, mflag_q}; // [RL5] [RL9]
					`TWS_A_MDATA: rdat_q <= {24'h000000, mrx_q};
					`TWS_A_SADDR: rdat_q <= saddr_q;
					`TWS_A_SDATA: rdat_q <= {24'h000000, buf_q};
					`TWS_A_SSTAT: rdat_q <= {26'h0000000, full_q, sflag_q};
					default: rdat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			presc_q <= 16'(`TWS_PRESC_RST);
			ctrl_q <= `TWS_CTRL_RST;
			saddr_q <= `TWS_SADDR_RST;
			mtx_q <= 8'h00;
		end else if (wr) begin
			if (wb_adr_i == `TWS_A_PRESC)
				presc_q <= 16'(mwr({16'h0000, presc_q}, wb_dat_i, wm)); // [RL3]
			if (wb_adr_i == `TWS_A_CTRL)
				ctrl_q <= 5'(mwr({27'h0000000, ctrl_q}, wb_dat_i, wm));
			if (wb_adr_i == `TWS_A_SADDR)
				saddr_q <= mwr(saddr_q, wb_dat_i, wm) & 32'h03FF_7F7F;
			if (wb_adr_i == `TWS_A_MDATA && wb_sel_i[0])
				mtx_q <= wb_dat_i[7:0];
		end
	end

	// input synchronisers and glitch filter
	for (genvar g = 0; g < 2; g++) begin : g_in
		logic s1_q;
		logic s2_q;
		logic f_q;
		logic [1:0] fc_q;
		assign flt[g] = f_q;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				s1_q <= 1'b1;
				s2_q <= 1'b1;
				f_q <= 1'b1;
				fc_q <= 2'h0;
			end else begin
				s1_q <= g ? serial_clock_line_i : serial_data_line_i;
				s2_q <= s1_q;
				if (s2_q == f_q) begin
					fc_q <= 2'h0;
				end else if (!ctrl_q[`TWS_C_FILT] || fc_q == 2'(`TWS_FILT_CYC - 1)) begin
					f_q <= s2_q; // [RL19]
					fc_q <= 2'h0;
				end else begin
					fc_q <= fc_q + 2'h1;
				end
			end
		end
	end

	// line events
	assign scl = flt[1];
	assign sda = flt[0];
	assign scl_r = scl & ~scl_p_q;
	assign scl_f = ~scl & scl_p_q;
	assign sta_det = scl & scl_p_q & sda_p_q & ~sda; // [RL20]
	assign sto_det = scl & scl_p_q & ~sda_p_q & sda; // [RL20]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			bus_busy_q <= 1'b0;
		end else begin
			scl_p_q <= scl;
			sda_p_q <= sda;
			if (sta_det)
				bus_busy_q <= 1'b1;
			else if (sto_det)
				bus_busy_q <= 1'b0;
		end
	end

	// master byte engine
	assign cmdw = wr & (wb_adr_i == `TWS_A_CMD) & wb_sel_i[0] & ctrl_q[`TWS_C_MEN];
	assign tdone = mcnt_q >= presc_q;
	assign own = msh_q[8] & ((cmd_q.wr & mbit_q < 4'h8) | (cmd_q.rd & mbit_q == 4'h8));
	assign hi_end = (scl & tdone) | (~scl & mhi_q); // [RL7]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ms_q <= tws_pkg::M_IDLE;
			cmd_q <= '0;
			mcnt_q <= 16'h0000;
			mbit_q <= 4'h0;
			msh_q <= 9'h000;
			mrx_q <= 8'h00;
			rxnak_q <= 1'b0;
			m_scl_q <= 1'b0;
			m_sda_q <= 1'b0;
			mhi_q <= 1'b0;
			mev_q <= 2'h0;
		end else begin
			mev_q <= 2'h0;
			mcnt_q <= mcnt_q + 16'h0001;
			case (ms_q)
				tws_pkg::M_IDLE: begin
					mcnt_q <= 16'h0000;
					if (!ctrl_q[`TWS_C_MEN]) begin
						m_scl_q <= 1'b0;
						m_sda_q <= 1'b0;
					end else if (cmdw && ms_q == tws_pkg::M_IDLE) begin
						cmd_q <= tws_pkg::tws_cmd_s'(wb_dat_i[4:0]);
						if (wb_dat_i[0])
							ms_q <= tws_pkg::M_STA0; // [RL4] [RL6]
						else if (wb_dat_i[2] | wb_dat_i[3])
							ms_q <= tws_pkg::M_LOAD; // [RL4]
						else if (wb_dat_i[1])
							ms_q <= tws_pkg::M_STO0; // [RL4]
					end
				end
				tws_pkg::M_STA0: begin
					m_sda_q <= 1'b0;
					if (bus_busy_q && !m_scl_q) begin
						ms_q <= tws_pkg::M_IDLE; // [RL8]
						mev_q <= 2'h3;
					end else if (tdone) begin
						mcnt_q <= 16'h0000;
						ms_q <= tws_pkg::M_STA1;
					end
				end
				tws_pkg::M_STA1: begin
					m_scl_q <= 1'b0;
					if (!scl) begin
						mcnt_q <= 16'h0000; // [RL2]
					end else if (tdone) begin
						mcnt_q <= 16'h0000;
						if (!sda) begin
							ms_q <= tws_pkg::M_IDLE; // [RL8]
							mev_q <= 2'h3;
						end else begin
							ms_q <= tws_pkg::M_STA2;
						end
					end
				end
				tws_pkg::M_STA2: begin
					m_sda_q <= 1'b1;
					if (tdone) begin
						mcnt_q <= 16'h0000;
						ms_q <= tws_pkg::M_STA3;
					end
				end
				tws_pkg::M_STA3: begin
					m_scl_q <= 1'b1;
					if (tdone) begin
						mcnt_q <= 16'h0000;
						if (cmd_q.rd | cmd_q.wr) begin
							ms_q <= tws_pkg::M_LOAD;
						end else begin
							ms_q <= tws_pkg::M_IDLE;
							mev_q <= 2'h1;
						end
					end
				end
				tws_pkg::M_LOAD: begin
					msh_q <= cmd_q.wr ? {mtx_q, 1'b1} : {8'hFF, cmd_q.nak}; // [RL4]
					mbit_q <= 4'h0;
					mcnt_q <= 16'h0000;
					ms_q <= tws_pkg::M_LOW;
				end
				tws_pkg::M_LOW: begin
					m_scl_q <= 1'b1; // [RL3]
					m_sda_q <= ~msh_q[8];
					if (tdone) begin
						mcnt_q <= 16'h0000;
						mhi_q <= 1'b0;
						ms_q <= tws_pkg::M_HIGH;
					end
				end
				tws_pkg::M_HIGH: begin
					m_scl_q <= 1'b0;
					if (scl)
						mhi_q <= 1'b1;
					else
						mcnt_q <= 16'h0000; // [RL2]
					if (scl && mhi_q && own && !sda) begin
						m_sda_q <= 1'b0; // [RL8]
						ms_q <= tws_pkg::M_IDLE;
						mev_q <= 2'h3;
					end else if (hi_end) begin
						m_scl_q <= 1'b1; // [RL7]
						mcnt_q <= 16'h0000;
						msh_q <= {msh_q[7:0], sda};
						mbit_q <= mbit_q + 4'h1;
						if (mbit_q != 4'h8) begin
							ms_q <= tws_pkg::M_LOW;
						end else begin
							mrx_q <= msh_q[7:0];
							rxnak_q <= sda;
							m_sda_q <= 1'b0;
							if (cmd_q.sto) begin
								ms_q <= tws_pkg::M_STO0;
							end else begin
								ms_q <= tws_pkg::M_IDLE;
								mev_q <= 2'h1; // [RL5]
							end
						end
					end
				end
				tws_pkg::M_STO0: begin
					m_scl_q <= 1'b1;
					m_sda_q <= 1'b1;
					if (tdone) begin
						mcnt_q <= 16'h0000;
						ms_q <= tws_pkg::M_STO1;
					end
				end
				tws_pkg::M_STO1: begin
					m_scl_q <= 1'b0;
					if (!scl) begin
						mcnt_q <= 16'h0000; // [RL2]
					end else if (tdone) begin
						mcnt_q <= 16'h0000;
						ms_q <= tws_pkg::M_STO2;
					end
				end
				tws_pkg::M_STO2: begin
					m_sda_q <= 1'b0;
					if (tdone) begin
						ms_q <= tws_pkg::M_IDLE;
						mev_q <= 2'h1; // [RL5]
					end
				end
				default: ms_q <= tws_pkg::M_IDLE;
			endcase
		end
	end

	// master sticky flags, set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mflag_q <= 2'h0;
			mirq_q <= 1'b0;
		end else begin
			mflag_q <= (mflag_q & ~((wr && wb_adr_i == `TWS_A_MSTAT && wb_sel_i[0]) ?
				wb_dat_i[1:0] : 2'h0)) | mev_q; // [RL5] [RL8]
			mirq_q <= |mflag_q;
		end
	end

	// slave address decode
	assign sact = sst_q != tws_pkg::S_IDLE && sst_q != tws_pkg::S_WAIT;
	assign sa = ssh_q[7:1];
	assign hit7 = (sa == saddr_q.a || sa == saddr_q.b) && !(sa[6:3] == 4'h0) &&
		!(sa[6:3] == 4'hF); // [RL11] [RL12]
	assign pre10 = ctrl_q[`TWS_C_TEN] && sa[6:2] == 5'h1E &&
		sa[1:0] == saddr_q.a10[9:8]; // [RL14]

	// slave byte engine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sst_q <= tws_pkg::S_IDLE;
			snx_q <= tws_pkg::S_IDLE;
			sbit_q <= 4'h0;
			ssh_q <= 8'h00;
			buf_q <= 8'h00;
			full_q <= 1'b0;
			txv_q <= 1'b0;
			ten_q <= 1'b0;
			mnak_q <= 1'b0;
			s_scl_q <= 1'b0;
			s_sda_q <= 1'b0;
			sev_q <= 5'h00;
		end else begin
			sev_q <= 5'h00;
			if (rd && wb_adr_i == `TWS_A_SDATA)
				full_q <= 1'b0;
			if (!ctrl_q[`TWS_C_SEN]) begin
				sst_q <= tws_pkg::S_IDLE;
				s_scl_q <= 1'b0;
				s_sda_q <= 1'b0;
			end else if (sta_det || sto_det) begin
				sev_q[`TWS_S_EOB] <= sst_q != tws_pkg::S_IDLE; // [RL18]
				// one clock rise is always seen before a stop or restart
				sev_q[`TWS_S_PERR] <= sact && sbit_q > 4'h1; // [RL18]
				sst_q <= sta_det ? tws_pkg::S_ADDR : tws_pkg::S_IDLE;
				if (sto_det)
					ten_q <= 1'b0;
				sbit_q <= 4'h0;
				s_scl_q <= 1'b0;
				s_sda_q <= 1'b0;
			end else begin
				if (scl_r && sact) begin
					sbit_q <= sbit_q + 4'h1;
					if (sst_q != tws_pkg::S_RD && sbit_q < 4'h8)
						ssh_q <= {ssh_q[6:0], sda};
					if (sbit_q == 4'h8)
						mnak_q <= sda;
				end
				if (scl_f && sact && sbit_q == 4'h8) begin
					s_sda_q <= 1'b0;
					snx_q <= tws_pkg::S_WAIT;
					case (sst_q)
						tws_pkg::S_ADDR: begin
							if (hit7 || (sa == 7'h00 && ctrl_q[`TWS_C_GC] &&
								!ctrl_q[`TWS_C_TEN])) begin
								s_sda_q <= 1'b1; // [RL11] [RL13]
								snx_q <= ssh_q[0] ? tws_pkg::S_RD : tws_pkg::S_WR;
							end else if (pre10 && (!ssh_q[0] || ten_q)) begin
								s_sda_q <= 1'b1; // [RL14]
								snx_q <= ssh_q[0] ? tws_pkg::S_RD : tws_pkg::S_ADDR2;
							end
						end
						tws_pkg::S_ADDR2: begin
							if (ssh_q == saddr_q.a10[7:0]) begin
								s_sda_q <= 1'b1; // [RL11]
								ten_q <= 1'b1;
								snx_q <= tws_pkg::S_WR;
							end
						end
						tws_pkg::S_WR: begin
							if (!full_q) begin
								buf_q <= ssh_q; // [RL16]
								full_q <= 1'b1;
								txv_q <= 1'b0; // [RL16]
								sev_q[`TWS_S_WAV] <= 1'b1; // [RL18]
								s_sda_q <= 1'b1;
								snx_q <= tws_pkg::S_WR;
							end
						end
						default: snx_q <= tws_pkg::S_RD;
					endcase
				end else if (scl_f && sact && sbit_q == 4'h9) begin
					sbit_q <= 4'h0;
					s_sda_q <= 1'b0;
					if (sst_q == tws_pkg::S_RD && mnak_q) begin
						sst_q <= tws_pkg::S_WAIT;
					end else begin
						sst_q <= snx_q; // [RL15]
						if (snx_q == tws_pkg::S_RD) begin
							s_scl_q <= 1'b1; // [RL10]
							sev_q[`TWS_S_RREQ] <= !txv_q; // [RL18]
						end
					end
				end else if (scl_f && sst_q == tws_pkg::S_RD && sbit_q != 4'h0) begin
					ssh_q <= {ssh_q[6:0], 1'b0};
					s_sda_q <= ~ssh_q[6];
				end else if (sst_q == tws_pkg::S_RD && s_scl_q && txv_q) begin
					ssh_q <= buf_q; // [RL17]
					s_sda_q <= ~buf_q[7];
					txv_q <= 1'b0;
					s_scl_q <= 1'b0;
					sev_q[`TWS_S_RTAK] <= 1'b1; // [RL18]
				end
			end
			if (wr && wb_adr_i == `TWS_A_SDATA && wb_sel_i[0]) begin
				buf_q <= wb_dat_i[7:0]; // [RL16]
				txv_q <= 1'b1;
			end
		end
	end

	// slave sticky flags, set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sflag_q <= 5'h00;
			sirq_q <= 1'b0;
		end else begin
			sflag_q <= (sflag_q & ~((wr && wb_adr_i == `TWS_A_SSTAT && wb_sel_i[0]) ?
				wb_dat_i[4:0] : 5'h00)) | sev_q; // [RL18]
			sirq_q <= |sflag_q;
		end
	end

	// open-drain pin drivers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lo_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			lo_q <= 1'b0; // [RL1]
			scl_oe_q <= m_scl_q | s_scl_q; // [RL1] [RL10]
			sda_oe_q <= m_sda_q | s_sda_q; // [RL1]
		end
	end

	assign serial_clock_line_o = lo_q;
	assign serial_data_line_o = lo_q;
	assign serial_clock_line_oe_o = scl_oe_q;
	assign serial_data_line_oe_o = sda_oe_q;
	assign master_irq_o = mirq_q;
	assign slave_irq_o = sirq_q;
endmodule : tws_top

// ==== sim/tws_chk.sv ====
// port checker for the two-wire controller
`timescale 1ns/10ps
`include "tws_defines.svh"
module tws_chk (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// serial lines
	input wire logic serial_clock_line_i,
	input wire logic serial_clock_line_o,
	input wire logic serial_clock_line_oe_o,
	input wire logic serial_data_line_o,
	input wire logic serial_data_line_oe_o,
	// events
	input wire logic master_irq_o,
	input wire logic slave_irq_o
);
	logic [15:0] presc_q;
	logic men_q;
	logic sen_q;
	logic [15:0] hi_q;
	logic [15:0] lo_q;
	logic mst;
	assign mst = men_q && !sen_q;
	// shadow of prescale and enables, taken at the accepting edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			presc_q <= 16'(`TWS_PRESC_RST);
			men_q <= 1'b0;
			sen_q <= 1'b0;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
			if (wb_adr_i == `TWS_A_PRESC && wb_sel_i[0])
				presc_q[7:0] <= wb_dat_i[7:0];
			if (wb_adr_i == `TWS_A_PRESC && wb_sel_i[1])
				presc_q[15:8] <= wb_dat_i[15:8];
			if (wb_adr_i == `TWS_A_CTRL && wb_sel_i[0])
				men_q <= wb_dat_i[0];
			if (wb_adr_i == `TWS_A_CTRL && wb_sel_i[0])
				sen_q <= wb_dat_i[1];
		end
	end
	// cycles the clock line has really been high while released
	always_ff @(posedge clk_i) begin
		if (rst_i || serial_clock_line_oe_o || !serial_clock_line_i)
			hi_q <= 16'h0000;
		else if (hi_q != 16'hFFFF)
			hi_q <= hi_q + 16'h0001;
	end
	// cycles the clock line has been pulled low by us
	always_ff @(posedge clk_i) begin
		if (rst_i || !serial_clock_line_oe_o)
			lo_q <= 16'h0000;
		else if (lo_q != 16'hFFFF)
			lo_q <= lo_q + 16'h0001;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_start;
		$rose(serial_data_line_oe_o) && serial_clock_line_i && !serial_clock_line_oe_o;
	endsequence
	a_ack_latency: assert property (disable iff (rst_i) s_take |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_read_zero: assert property (disable iff (rst_i) s_take and !wb_we_i &&
		(wb_adr_i == `TWS_A_CMD || wb_adr_i > `TWS_A_SSTAT) |=> wb_dat_o == 32'h0)
		else $error("nonzero read of command or unmapped place");
	a_reset_quiet: assert property (rst_i |=> !wb_ack_o && !serial_clock_line_oe_o &&
		!serial_data_line_oe_o && !master_irq_o && !slave_irq_o)
		else $error("outputs active after reset");
	a_lines_low: assert property (disable iff (rst_i)
		!serial_clock_line_o && !serial_data_line_o)
		else $error("line driven high");
	a_idle_free: assert property (disable iff (rst_i) !men_q && !sen_q |=>
		!serial_clock_line_oe_o && !serial_data_line_oe_o)
		else $error("line pulled while disabled");
	a_high_time: assert property (disable iff (rst_i)
		$rose(serial_clock_line_oe_o) && $past(serial_clock_line_i) && mst |->
		hi_q >= presc_q + 16'h0001)
		else $error("clock high phase too short");
	a_low_time: assert property (disable iff (rst_i)
		$fell(serial_clock_line_oe_o) && mst |-> lo_q >= presc_q + 16'h0001)
		else $error("clock low phase too short");
	a_start_clock: assert property (disable iff (rst_i)
		s_start ##0 mst |-> ##[1:1000] serial_clock_line_oe_o)
		else $error("no clock fall after start");
	a_irq_done: assert property (disable iff (rst_i) wb_ack_o && !wb_we_i &&
		wb_adr_i == `TWS_A_MSTAT && wb_dat_o[1:0] != 2'b00 |-> master_irq_o)
		else $error("master interrupt low with flag set");
endmodule : tws_chk
bind tws_top tws_chk i_tws_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_clock_line_i(serial_clock_line_i),
	.serial_clock_line_o(serial_clock_line_o), .serial_clock_line_oe_o(serial_clock_line_oe_o),
	.serial_data_line_o(serial_data_line_o), .serial_data_line_oe_o(serial_data_line_oe_o),
	.master_irq_o(master_irq_o), .slave_irq_o(slave_irq_o)
);

// ==== sim/tws_peer.sv ====
// behavioural two-wire slave device on the far side of the bus
`timescale 1ns/10ps
module tws_peer #(
	parameter logic [6:0] ADDR = 7'h50,
	parameter logic [7:0] TX = 8'hC5,
	parameter int STRETCH = 20
) (
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// resolved bus levels
	input wire logic scl_i,
	input wire logic sda_i,
	// pulls, high pulls the line low
	output logic scl_oe_o,
	output logic sda_oe_o,
	// last written byte
	output logic [7:0] rx_o
);
	logic scl_q;
	logic sda_q;
	logic rd_q;
	logic [7:0] sh_q;
	logic [3:0] bit_q;
	logic [1:0] ph_q;
	int st_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{scl_q, sda_q, scl_oe_o, sda_oe_o, rd_q} <= 5'h18;
			{sh_q, bit_q, ph_q, rx_o} <= 22'h0;
			st_q <= 0;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			if (st_q > 0)
				st_q <= st_q - 1;
			else
				scl_oe_o <= 1'b0; // only pull or release
			if (scl_i && scl_q && sda_q && !sda_i) begin // start
				ph_q <= 2'h1;
				bit_q <= 4'h0;
			end else if (scl_i && scl_q && !sda_q && sda_i) begin // stop
				ph_q <= 2'h0;
				sda_oe_o <= 1'b0;
			end else if (scl_i && !scl_q && ph_q != 2'h0) begin
				sh_q <= {sh_q[6:0], sda_i}; // msb first
				bit_q <= bit_q + 4'h1;
			end else if (!scl_i && scl_q && ph_q != 2'h0) begin
				scl_oe_o <= STRETCH > 0; // stretch after the master's fall
				st_q <= STRETCH;
				sda_oe_o <= 1'b0;
				if (bit_q == 4'h8 && ph_q == 2'h1) begin
					sda_oe_o <= sh_q[7:1] == ADDR; // ack own address only
					rd_q <= sh_q[0];
					if (sh_q[7:1] != ADDR)
						ph_q <= 2'h0;
				end else if (bit_q == 4'h8 && ph_q == 2'h2) begin
					sda_oe_o <= 1'b1;
					rx_o <= sh_q;
				end else if (bit_q == 4'h9) begin
					bit_q <= 4'h0;
					if (ph_q == 2'h1)
						ph_q <= rd_q ? 2'h3 : 2'h2;
					if (ph_q == 2'h3 && sh_q[0])
						ph_q <= 2'h0;
					else if (ph_q == 2'h3 || (ph_q == 2'h1 && rd_q))
						sda_oe_o <= !TX[7];
				end else if (ph_q == 2'h3 && bit_q < 4'h8) begin
					sda_oe_o <= !TX[3'(4'h7 - bit_q)];
				end
			end
		end
	end
endmodule : tws_peer

// ==== sim/testbench.sv ====
// self-checking bench for the two-wire controller as bus master and, by loopback, as slave
`timescale 1ns/10ps
`include "tws_defines.svh"
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic hold = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic [31:0] st;
	logic ack, scl, sda, scl_oe, sda_oe, p_scl_oe, p_sda_oe, m_irq, s_irq;
	logic [7:0] p_rx;
	logic [7:0] zero_adr [6] = '{`TWS_A_CTRL, `TWS_A_CMD, `TWS_A_MSTAT, `TWS_A_SADDR,
		`TWS_A_SSTAT, 8'h20};
	int error_cnt = 0;
	int total_checks = 0;
	// wired-and with pull-ups
	assign scl = !(scl_oe || p_scl_oe);
	assign sda = !(sda_oe || p_sda_oe || hold);
	always #12.5 clk_i = ~clk_i;
	tws_top i_tws_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .serial_clock_line_i(scl), .serial_data_line_i(sda),
		.serial_clock_line_o(), .serial_clock_line_oe_o(scl_oe), .serial_data_line_o(),
		.serial_data_line_oe_o(sda_oe), .master_irq_o(m_irq), .slave_irq_o(s_irq));
	tws_peer i_tws_peer (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
		.scl_oe_o(p_scl_oe), .sda_oe_o(p_sda_oe), .rx_o(p_rx));
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	// byte into the transmit buffer, command, then poll and clear done
	task automatic xfer(input logic [7:0] d, input logic [4:0] c);
		wb(1'b1, `TWS_A_MDATA, {24'h0, d}, 4'hF, q);
		wb(1'b1, `TWS_A_CMD, {27'h0, c}, 4'hF, q);
		st = 32'h0;
		while (st[0] !== 1'b1)
			wb(1'b0, `TWS_A_MSTAT, 32'h0, 4'hF, st);
		chk({31'h0, m_irq}, 32'h1);
		wb(1'b1, `TWS_A_MSTAT, 32'h3, 4'hF, q);
		@(posedge clk_i);
		chk({31'h0, m_irq}, 32'h0);
	endtask : xfer
	initial begin
		repeat (30000) @(posedge clk_i);
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({30'h0, scl, sda}, 32'h3);
		wb(1'b0, `TWS_A_PRESC, 32'h0, 4'hF, q);
		chk(q, 32'(`TWS_PRESC_RST));
		foreach (zero_adr[i]) begin
			wb(1'b0, zero_adr[i], 32'h0, 4'hF, q);
			chk(q, 32'h0);
		end
		wb(1'b1, `TWS_A_PRESC, 32'h0000_0004, 4'h3, q);
		wb(1'b0, `TWS_A_PRESC, 32'h0, 4'hF, q);
		chk(q, 32'h4);
		wb(1'b1, `TWS_A_CTRL, 32'h1, 4'hF, q);
		xfer(8'hA0, 5'h09);
		chk(st & 32'h17, 32'h11);
		xfer(8'h3C, 5'h0A);
		chk(st & 32'h07, 32'h01);
		chk({24'h0, p_rx}, 32'h3C);
		wb(1'b0, `TWS_A_MSTAT, 32'h0, 4'hF, q);
		chk(q & 32'h17, 32'h0);
		xfer(8'hA1, 5'h09);
		chk(st & 32'h07, 32'h01);
		xfer(8'h00, 5'h16);
		chk(st & 32'h03, 32'h01);
		wb(1'b0, `TWS_A_MDATA, 32'h0, 4'hF, q);
		chk(q & 32'hFF, 32'hC5);
		xfer(8'h44, 5'h09);
		chk(st & 32'h07, 32'h05);
		xfer(8'h00, 5'h02);
		xfer(8'hA0, 5'h09);
		hold <= 1'b1;
		xfer(8'hFF, 5'h08);
		chk(st & 32'h03, 32'h03);
		chk({30'h0, scl_oe, sda_oe}, 32'h0);
		repeat (40) @(posedge clk_i);
		hold <= 1'b0;
		repeat (10) @(posedge clk_i);
		wb(1'b0, `TWS_A_MSTAT, 32'h0, 4'hF, q);
		chk(q & 32'h10, 32'h0);
		// loopback: own slave at 7'h2A answers own master
		wb(1'b1, `TWS_A_SADDR, 32'h0000_002A, 4'hF, q);
		wb(1'b1, `TWS_A_CTRL, 32'h3, 4'hF, q);
		xfer(8'h54, 5'h09);
		chk(st & 32'h07, 32'h01);
		xfer(8'h96, 5'h08);
		chk(st & 32'h07, 32'h01);
		xfer(8'h3B, 5'h0A);
		chk(st & 32'h07, 32'h05);
		wb(1'b0, `TWS_A_SSTAT, 32'h0, 4'hF, q);
		chk(q & 32'h3F, 32'h2C);
		chk({31'h0, s_irq}, 32'h1);
		wb(1'b0, `TWS_A_SDATA, 32'h0, 4'hF, q);
		chk(q & 32'hFF, 32'h96);
		wb(1'b1, `TWS_A_SSTAT, 32'h1F, 4'hF, q);
		wb(1'b0, `TWS_A_SSTAT, 32'h0, 4'hF, q);
		chk(q & 32'h3F, 32'h0);
		chk({31'h0, s_irq}, 32'h0);
		stop_test();
	end
endmodule : testbench
